// [design/t1_codec_pkg.sv]
// Shared constants and types of the T1 section line codec
package t1_codec_pkg;

  // ==================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] ISTAT_OFS = 8'h08;
  localparam logic [7:0] IMASK_OFS = 8'h0c;

  // ==================================================
  // Port monitor setting
  typedef enum logic [1:0] {
    PM_NMON = 2'b00,
    PM_MON  = 2'b01,
    PM_AUTO = 2'b10
  } port_mon_t;

  // Control register, bit 0 upward: tx_act, rx_act, b8zs, port_mon
  typedef struct packed {
    port_mon_t port_mon;
    logic      b8zs;
    logic      rx_act;
    logic      tx_act;
  } ctrl_t;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Status register, bit 0 upward: los, fault_cause, server_fail
  typedef struct packed {
    logic server_fail;
    logic fault_cause;
    logic los;
  } status_t;

  // Interrupt events, bit 0 upward: los_set, los_clear, code_viol
  typedef struct packed {
    logic code_viol;
    logic los_clear;
    logic los_set;
  } evt_t;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ==================================================
  // Line symbols and zero substitution
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_MARK = 2'h1;
  localparam logic [1:0] SYM_VIOL = 2'h2;
  localparam int         ZS_LEN   = 8;
  // Oldest first: 0 0 0 V B 0 V B
  localparam logic [15:0] ZS_PATTERN = 16'h0249;

  // ==================================================
  // Timing
  localparam int CLK_KHZ  = 100000;
  localparam int BIT_KBPS = 1544;
  localparam int NCO_W    = 24;
  localparam logic [23:0] NCO_INC =
    24'((64'(BIT_KBPS) << NCO_W) / 64'(CLK_KHZ));
  localparam int BIT_CYC = (CLK_KHZ + BIT_KBPS - 1) / BIT_KBPS;
  localparam int FILL_LIMIT_US  = 250;
  localparam int FILL_LIMIT_CYC = FILL_LIMIT_US * CLK_KHZ / 1000;
  localparam int LOS_ZERO_BITS  = 175;
  localparam int LOS_MIN_ONES   = 22;

endpackage

// [design/t1_line_encoder.sv]
// Transmit line encoder: AMI or B8ZS onto dual-rail line pulses
`timescale 1ns/10ps
`default_nettype none
module t1_line_encoder #(
  parameter int DEPTH = t1_codec_pkg::ZS_LEN
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic bit_tick_i,
  input  wire logic bit_data_i,
  input  wire logic b8zs_i,
  input  wire logic active_i,
  output logic      pos_o,
  output logic      neg_o
);
  import t1_codec_pkg::*;

  // ==================================================
  // Elaboration check
  if (DEPTH != ZS_LEN) begin : g_depth_bad
    $error("Encoder depth must equal the substitution length");
  end

  logic [2*DEPTH-1:0] pipe_r;
  logic [2*DEPTH-1:0] shifted;
  logic [2*DEPTH-1:0] pipe_nxt;
  logic [1:0]         out_sym;
  logic               last_pos_r;
  logic               pulse;
  logic               pulse_pos;

  // ==================================================
  // Symbol window; eight pending zeros become the fill pattern
  assign shifted  = {pipe_r[2*DEPTH-3:0], 1'b0, bit_data_i};
  assign pipe_nxt = (b8zs_i && shifted == '0) ? ZS_PATTERN : shifted;

  // Oldest symbol leaves; violations repeat the last polarity
  assign out_sym   = pipe_r[2*DEPTH-1 -: 2];
  assign pulse     = (out_sym != SYM_ZERO);
  assign pulse_pos = (out_sym == SYM_VIOL) ? last_pos_r : ~last_pos_r;

  always_ff @(posedge clock_i) begin
    if (srst_i || !active_i) begin
      pipe_r     <= '0;
      last_pos_r <= 1'b0;
      pos_o      <= 1'b0;
      neg_o      <= 1'b0;
    end else if (bit_tick_i) begin
      pipe_r <= pipe_nxt;
      pos_o  <= pulse & pulse_pos;
      neg_o  <= pulse & ~pulse_pos;
      if (pulse) begin
        last_pos_r <= pulse_pos;
      end
    end
  end

endmodule
`default_nettype wire

// [design/t1_section_codec.sv]
// T1 section layer codec: line coding, loss of signal and alarm fill
//
// Summary of operation
// - Detect loss of signal; drive trail fail
// - Fault cause only when monitored and lost
// - Automatic monitor state left out
// - Encode client data, AMI or B8ZS
// - Decode line with the configured code
// - Recover bit clock for client and sync
// - Decode cleanly within 50 ppm of rate
// - Trail fail gives server fail, all-ones fill
`timescale 1ns/10ps
`default_nettype none
module t1_section_codec #(
  parameter int LOS_BITS = t1_codec_pkg::LOS_ZERO_BITS,
  parameter int LOS_ONES = t1_codec_pkg::LOS_MIN_ONES,
  parameter int FILL_CYC = t1_codec_pkg::FILL_LIMIT_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Client transmit side
  input  wire logic        client_bit_clock_i,
  input  wire logic        client_data_i,
  // Coded line, dual rail
  output logic             line_tx_pos_o,
  output logic             line_tx_neg_o,
  input  wire logic        line_rx_pos_i,
  input  wire logic        line_rx_neg_i,
  // Client receive side
  output logic             client_data_o,
  output logic             client_clock_o,
  output logic             sync_clock_o,
  output logic             client_server_fail_o,
  output logic             signal_loss_fault_cause_o,
  output logic             irq_o
);
  import t1_codec_pkg::*;

  // ==================================================
  // Elaboration checks
  if (LOS_BITS < 2 || LOS_BITS > 255 || LOS_ONES > LOS_BITS) begin : g_los_bad
    $error("Loss of signal counts out of range");
  end
  if ((ZS_LEN + 2) * BIT_CYC > FILL_CYC) begin : g_fill_bad
    $error("Alarm fill latency exceeds its limit");
  end

  localparam logic [7:0] LOS_LAST = 8'(LOS_BITS - 1);
  localparam logic [7:0] LOS_MIN  = 8'(LOS_ONES);

  // ==================================================
  // Declarations
  ctrl_t       ctrl_r;
  status_t     stat;
  evt_t        evt;
  logic [2:0]  istat_r;
  logic [2:0]  istat_nxt;
  logic [2:0]  imask_r;
  logic [31:0] rd_data;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_istat;
  logic        sel_imask;
  logic        addr_ok;
  logic        setup;
  logic        wr_en;
  port_mon_t   wr_mon;
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic [3:0]  prev_r;
  logic        tx_tick;
  logic        rx_mark;
  logic        rx_edge;
  logic [NCO_W-1:0] phase_r;
  logic [NCO_W-1:0] phase_nxt;
  logic        samp;
  logic        seen_r;
  logic        seen_pos_r;
  logic [15:0] rxw_r;
  logic [15:0] rx_shift;
  logic        prior_pos;
  logic        last_pos_r;
  logic        pol_valid_r;
  logic        zs_hit;
  logic        decoded;
  logic [7:0]  zero_run_r;
  logic [7:0]  win_r;
  logic [7:0]  ones_r;
  logic        win_end;
  logic        los_r;
  logic        trail_fail_in;

  // ==================================================
  // APB decode
  assign setup     = psel_i & ~penable_i;
  assign sel_ctrl  = (paddr_i == CTRL_OFS);
  assign sel_stat  = (paddr_i == STAT_OFS);
  assign sel_istat = (paddr_i == ISTAT_OFS);
  assign sel_imask = (paddr_i == IMASK_OFS);
  assign addr_ok   = sel_ctrl | sel_stat | sel_istat | sel_imask;
  // Write lands at the edge that completes the access
  assign wr_en     = psel_i & penable_i & pready_o & pwrite_i;

  // Read data selection, unmapped reads as zero
  assign rd_data =
    sel_ctrl  ? {27'h0, ctrl_r}  :
    sel_stat  ? {29'h0, stat}    :
    sel_istat ? {29'h0, istat_r} :
    sel_imask ? {29'h0, imask_r} :
    32'h00000000;

  assign wr_mon = (port_mon_t'(pwdata_i[4:3]) == PM_MON) ? PM_MON
                                                          : PM_NMON;

  // Answer one cycle after setup; error on unmapped address
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~addr_ok;
      prdata_o  <= (setup && !pwrite_i) ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_r  <= ctrl_t'(CTRL_RST);
      imask_r <= IRQ_RST;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_r <= {wr_mon, pwdata_i[2:0]};
      end
      if (sel_imask) begin
        imask_r <= pwdata_i[2:0];
      end
    end
  end

  // ==================================================
  // Pin synchronisers: tx clock, tx data, rx pos, rx neg
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r  <= 4'h0;
    end else begin
      sync1_r <= {line_rx_neg_i, line_rx_pos_i,
                  client_data_i, client_bit_clock_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ==================================================
  // Transmit adaptation
  // sample on client clock rise
  assign tx_tick = sync2_r[0] & ~prev_r[0];

  t1_line_encoder #(
    .DEPTH (ZS_LEN)
  ) u_encoder (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .bit_tick_i (tx_tick),
    .bit_data_i (sync2_r[1]),
    .b8zs_i     (ctrl_r.b8zs),
    .active_i   (ctrl_r.tx_act),
    .pos_o      (line_tx_pos_o),
    .neg_o      (line_tx_neg_o)
  );

  // ==================================================
  // Receive bit timing
  assign rx_mark = sync2_r[2] | sync2_r[3];
  assign rx_edge = rx_mark & ~(prev_r[2] | prev_r[3]);

  assign phase_nxt = rx_edge ? '0 : phase_r + NCO_INC;
  assign samp = ~phase_r[NCO_W-1] & phase_nxt[NCO_W-1];

  // Phase accumulator and pulse catcher; a new pulse wins over the sample clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      phase_r    <= '0;
      seen_r     <= 1'b0;
      seen_pos_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      if (rx_edge) begin
        seen_r     <= 1'b1;
        seen_pos_r <= sync2_r[2];
      end else if (samp) begin
        seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      client_clock_o <= 1'b0;
      sync_clock_o   <= 1'b0;
    end else begin
      client_clock_o <= ~phase_r[NCO_W-1];
      sync_clock_o   <= ~phase_r[NCO_W-1];
    end
  end

  // ==================================================
  // Receive decoder: window of {mark, positive} per bit
  assign rx_shift  = {rxw_r[13:0], seen_r, seen_pos_r};
  assign prior_pos = rxw_r[15] ? rxw_r[14] : last_pos_r;

  assign zs_hit = ctrl_r.b8zs
                & ~rx_shift[15] & ~rx_shift[13] & ~rx_shift[11]
                & rx_shift[9] & (rx_shift[8] == prior_pos)
                & rx_shift[7] & (rx_shift[6] != prior_pos)
                & ~rx_shift[5]
                & rx_shift[3] & (rx_shift[2] != prior_pos)
                & rx_shift[1] & (rx_shift[0] == prior_pos);

  assign decoded = rxw_r[15];

  // Bipolar violation outside a substitution
  assign evt.code_viol = samp & ctrl_r.rx_act & rxw_r[15]
                       & pol_valid_r & (rxw_r[14] == last_pos_r);

  always_ff @(posedge clock_i) begin
    if (srst_i || !ctrl_r.rx_act) begin
      rxw_r       <= 16'h0000;
      last_pos_r  <= 1'b0;
      pol_valid_r <= 1'b0;
    end else if (samp) begin
      rxw_r      <= zs_hit ? 16'h0000 : rx_shift;
      last_pos_r <= prior_pos;
      if (rxw_r[15]) begin
        pol_valid_r <= 1'b1;
      end
    end
  end

  // ==================================================
  // Receive termination: loss of signal
  assign win_end = samp & (win_r == LOS_LAST);

  assign evt.los_set = samp & ~los_r & ~seen_r
                     & (zero_run_r == LOS_LAST);
  assign evt.los_clear = win_end & los_r
                       & ((ones_r + 8'(seen_r)) >= LOS_MIN);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      zero_run_r <= 8'h00;
      win_r      <= 8'h00;
      ones_r     <= 8'h00;
      los_r      <= 1'b0;
    end else if (samp) begin
      if (seen_r) begin
        zero_run_r <= 8'h00;
      end else if (zero_run_r != LOS_LAST) begin
        zero_run_r <= zero_run_r + 8'h01;
      end
      if (win_end || evt.los_set) begin
        win_r  <= 8'h00;
        ones_r <= 8'h00;
      end else begin
        win_r  <= win_r + 8'h01;
        ones_r <= ones_r + 8'(seen_r);
      end
      if (evt.los_set) begin
        los_r <= 1'b1;
      end else if (evt.los_clear) begin
        los_r <= 1'b0;
      end
    end
  end

  assign trail_fail_in = los_r;

  // ==================================================
  // Consequent actions and fault cause
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      client_server_fail_o      <= 1'b0;
      signal_loss_fault_cause_o <= 1'b0;
    end else begin
      client_server_fail_o <= trail_fail_in;
      signal_loss_fault_cause_o <= (ctrl_r.port_mon == PM_MON) & los_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      client_data_o <= 1'b0;
    end else if (samp) begin
      client_data_o <= trail_fail_in | (ctrl_r.rx_act & decoded);
    end
  end

  // ==================================================
  // Status and interrupts
  assign stat.los         = los_r;
  assign stat.fault_cause = signal_loss_fault_cause_o;
  assign stat.server_fail = client_server_fail_o;

  // Write one clears; a new event wins over the clear
  assign istat_nxt = (istat_r & ~((wr_en && sel_istat) ? pwdata_i[2:0]
                                                       : 3'h0))
                   | evt;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      istat_r <= IRQ_RST;
      irq_o   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_o   <= |(istat_r & imask_r);
    end
  end

endmodule
`default_nettype wire

// [sim/t1_section_codec_props.sv]
// Port-level assertions for the T1 section codec
`timescale 1ns/10ps
`default_nettype none
module t1_section_codec_props #(
  parameter int LOS_BITS = 16
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic line_rx_pos_i,
  input wire logic line_rx_neg_i,
  input wire logic line_tx_pos_o,
  input wire logic line_tx_neg_o,
  input wire logic client_data_o,
  input wire logic client_clock_o,
  input wire logic sync_clock_o,
  input wire logic client_server_fail_o,
  input wire logic signal_loss_fault_cause_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ==========
  // Cycles since the last pulse level on the receive rails
  logic [15:0] quiet_r;
  always_ff @(posedge clock_i) begin
    if (srst_i || line_rx_pos_i || line_rx_neg_i) begin
      quiet_r <= '0;
    end else if (quiet_r != 16'hffff) begin
      quiet_r <= quiet_r + 16'h1;
    end
  end
  // ==========
  // Checks
  setup_ready_a: assert property (
    psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  ready_cause_a: assert property (
    pready_o |-> $past(psel_i) && !$past(penable_i)) else $error("ready without setup");
  los_quiet_a: assert property (
    $rose(client_server_fail_o) |-> quiet_r >= 16'(LOS_BITS * 60)) else $error("early loss");
  cause_gate_a: assert property (
    signal_loss_fault_cause_o |-> client_server_fail_o) else $error("cause without defect");
  rails_excl_a: assert property (
    !(line_tx_pos_o && line_tx_neg_o)) else $error("both tx rails high");
  sync_copy_a: assert property (
    sync_clock_o == client_clock_o) else $error("sync clock differs");
  fill_on_a: assert property (
    $rose(client_server_fail_o) |-> ##[0:150] (client_data_o || !client_server_fail_o))
    else $error("no all-ones fill");
  fill_hold_a: assert property (
    client_server_fail_o && client_data_o |=> client_data_o || !client_server_fail_o)
    else $error("fill dropped");
endmodule
`default_nettype wire

// [sim/t1_line_partner.sv]
// Far end of the coded line: return-to-zero loopback with a cut switch
`timescale 1ns/10ps
`default_nettype none
module t1_line_partner (
  input  wire logic clock_i,
  input  wire logic tx_pos_i,
  input  wire logic tx_neg_i,
  input  wire logic cut_i,
  output logic      rx_pos_o,
  output logic      rx_neg_o,
  output int        viol_o
);
  logic       pos_d = 1'b0;
  logic       neg_d = 1'b0;
  logic       last_neg = 1'b1;
  logic [4:0] len_r = '0;
  initial begin
    rx_pos_o = 1'b0;
    rx_neg_o = 1'b0;
    viol_o = 0;
  end
  // Each new mark becomes a short pulse; a cut line rests at no pulse
  always @(posedge clock_i) begin
    pos_d <= tx_pos_i;
    neg_d <= tx_neg_i;
    if (len_r != 5'h0) begin
      len_r <= len_r - 5'h1;
    end else begin
      rx_pos_o <= 1'b0;
      rx_neg_o <= 1'b0;
    end
    if ((tx_pos_i && !pos_d) || (tx_neg_i && !neg_d)) begin
      len_r <= 5'h18;
      rx_pos_o <= tx_pos_i && !cut_i;
      rx_neg_o <= tx_neg_i && !cut_i;
      viol_o <= viol_o + int'(tx_neg_i == last_neg); // Same polarity twice
      last_neg <= tx_neg_i;
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench of the T1 section codec
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import t1_codec_pkg::*;
  localparam logic [31:0] PAT = 32'hb000_0d01;
  logic clock_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, cbc = 0, cdat = 1;
  logic [7:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd, rx_sh = '1, src = '1;
  logic pready_o, pslverr_o, tx_p, tx_n, rx_p, rx_n, cdo, cco, sco, ssf, flc, irq_o, err;
  logic cut = 0, seen = 0, load = 0;
  int num_errors = 0, n_tests = 0, cyc = 0, viol, v0, frac = 0;
  t1_section_codec #(.LOS_BITS(24), .LOS_ONES(2)) i_dut (.clock_i, .srst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .client_bit_clock_i(cbc), .client_data_i(cdat), .line_tx_pos_o(tx_p),
    .line_tx_neg_o(tx_n), .line_rx_pos_i(rx_p), .line_rx_neg_i(rx_n), .client_data_o(cdo),
    .client_clock_o(cco), .sync_clock_o(sco), .client_server_fail_o(ssf),
    .signal_loss_fault_cause_o(flc), .irq_o);
  t1_line_partner i_line (.clock_i, .tx_pos_i(tx_p), .tx_neg_i(tx_n), .cut_i(cut),
    .rx_pos_o(rx_p), .rx_neg_o(rx_n), .viol_o(viol));
  initial forever #5 clock_i = ~clock_i;
  // Client bit clock averaging 1 544 kHz: seven bits in thirty last 64 cycles, the rest 65
  // Data shifted out at its fall; a load request starts the test word
  initial forever begin
    repeat (32) @(posedge clock_i);
    cbc <= 1'b1;
    frac = (frac + 7) % 30;
    repeat ((frac < 7) ? 32 : 33) @(posedge clock_i);
    cbc <= 1'b0;
    cdat <= load ? PAT[31] : src[31];
    src <= load ? {PAT[30:0], 1'b1} : {src[30:0], 1'b1};
    load = 1'b0;
  end
  // Decoded stream watched for the test word
  always @(posedge cco) begin
    rx_sh <= {rx_sh[30:0], cdo};
    if ({rx_sh[30:0], cdo} == PAT) seen <= 1'b1;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    while (pready_o !== 1'b1) @(posedge clock_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wait_for(input logic sel, input logic v);
    while ((sel ? seen : ssf) !== v) @(posedge clock_i);
  endtask
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, '0);
    `CHK(rd, 32'h0)
    apb(1'b1, CTRL_OFS, 32'h1f);
    apb(1'b0, CTRL_OFS, '0);
    `CHK(rd, 32'h07)
    apb(1'b1, 8'h10, 32'h1);
    `CHK(err, 1'b1)
  endtask
  task automatic t_loop(input logic z);
    apb(1'b1, CTRL_OFS, {27'h0, PM_MON, z, 2'b11});
    wait_for(1'b0, 1'b0);
    repeat (400) @(posedge clock_i);
    v0 = viol;
    seen = 1'b0;
    load = 1'b1;
    wait_for(1'b1, 1'b1);
    `CHK(seen, 1'b1)
    `CHK(viol - v0, z ? 4 : 0)
  endtask
  task automatic t_los();
    apb(1'b1, IMASK_OFS, 32'h1);
    cut <= 1'b1;
    wait_for(1'b0, 1'b1);
    repeat (150) @(posedge clock_i);
    `CHK(cdo, 1'b1)
    `CHK(flc, 1'b1)
    `CHK(irq_o, 1'b1)
    apb(1'b0, STAT_OFS, '0);
    `CHK(rd, 32'h7)
    apb(1'b1, CTRL_OFS, 32'h03);
    apb(1'b1, ISTAT_OFS, 32'h7);
    repeat (2) @(posedge clock_i);
    `CHK(flc, 1'b0)
    `CHK(irq_o, 1'b0)
    cut <= 1'b0;
    wait_for(1'b0, 1'b0);
    repeat (3) @(posedge clock_i);
    `CHK(irq_o, 1'b0)
    apb(1'b0, ISTAT_OFS, '0);
    `CHK(rd[1], 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    t_regs();
    t_loop(1'b0);
    t_los();
    t_loop(1'b1);
    stop_test();
  end
endmodule
bind t1_section_codec t1_section_codec_props #(.LOS_BITS(LOS_BITS)) i_props (.clock_i,
  .srst_i, .psel_i, .penable_i, .pready_o, .line_rx_pos_i, .line_rx_neg_i, .line_tx_pos_o,
  .line_tx_neg_o, .client_data_o, .client_clock_o, .sync_clock_o, .client_server_fail_o,
  .signal_loss_fault_cause_o);
`default_nettype wire
